// ===== toi_opcode_interp.sv
// Notes on behaviour
// (RULE1) Trigger-matching command sets matching, automatic reject and token holding.
// (RULE2) Continuous-storage command clears matching, automatic reject and trigger subtraction.
// (RULE3) Mode query waits until the host reads one word at the command location.
// (RULE4) Mode query word bit 0: one is trigger matching, zero continuous storage.
// (RULE5) Token holding set: chips move data until event end or empty.
// (RULE6) Token holding cleared: chips move one word per transfer.
// (RULE7) Load-defaults sets the documented window values, matching off, all channels on.
// (RULE8) Auto-load flag clear: defaults applied at power-on and global reset.
// (RULE9) Save-user stores mode, window values and channel pattern in non-volatile store.
// (RULE10) Load-user restores the saved configuration and reprograms the setup.
// (RULE11) Auto-load-user sets the flag; saved configuration applied at next reset.
// (RULE12) Auto-load-default clears the flag; defaults applied at next reset.
// (RULE13) Old firmware hosts wait over ten milliseconds after non-volatile writes.
// (RULE14) Identity read returns two words of the indexed chip's 32-bit identity.
// (RULE15) Lock read returns one word with the chip's lock bit.
// (RULE16) Error read returns one word with the chip's eleven error bits.
// (RULE17) Setup words written and read by index; load and reload reprogram setup.
// (RULE18) Trim set takes twelve bits per chip and reprograms; trim read returns them.
// (RULE19) Channel pattern write takes eight words, then control registers reprogram.
// (RULE20) FIFO size command takes three bits and reprograms the setup.
// (RULE21) Fault skip and fault tag enable and disable commands reprogram setup.
// (RULE22) Byte write takes address then data; byte read takes address, returns byte.
// (RULE23) Write-ok drops on each accepted write and returns when ready again.
// (RULE24) Opcode first; no-operand commands finish at once, others wait for operands.
// (RULE25) Upper opcode byte is the command, lower byte the object index.
`timescale 1ns/1ps
module toi_opcode_interp (
    input  wire logic                        core_clk,
    input  wire logic                        rst,
    input  wire logic                        nv_init,
    input  wire toi_pkg::toi_bus_type        bus,
    output logic [15:0]                      rdata,
    input  wire toi_pkg::toi_chip_type [3:0] chip_stat,
    input  wire logic [6:0]                  setup_idx,
    output logic [15:0]                      setup_data,
    output toi_pkg::toi_cfg_type             cfg,
    output logic                             setup_reprog,
    output logic                             setup_default,
    output logic                             ctrl_reprog,
    output logic                             write_ok,
    output logic                             read_ok
);
    toi_pkg::toi_state_type state;
    toi_pkg::toi_op_type    op;
    toi_pkg::toi_user_type  nv_user;
    logic [15:0]            opcode;
    logic [7:0]             cmd;
    logic [7:0]             obj;
    logic [3:0]             wcnt;
    logic [3:0]             rcnt;
    logic [15:0]            opnd [8];
    logic [15:0]            rd_word;
    logic [15:0]            next_rd_word;
    logic [15:0]            setup_mem [128];
    logic [7:0]             nv_mem [256];
    logic                   auto_load;
    logic                   wr_micro;
    logic                   rd_micro;
    logic                   done;

    assign cmd = opcode[15:8]; // RULE25
    assign obj = opcode[7:0]; // RULE25
    assign op = toi_pkg::toi_decode(cmd);
    assign wr_micro = bus.wr && bus.addr == toi_pkg::TOI_ADDR_MICRO;
    assign rd_micro = bus.rd && bus.addr == toi_pkg::TOI_ADDR_MICRO;
    // Handshake bits follow the sequencer directly so the host never sees a stale flag
    assign write_ok = state == toi_pkg::TOI_IDLE || state == toi_pkg::TOI_WAIT_WR; // RULE23
    assign read_ok = state == toi_pkg::TOI_WAIT_RD;
    assign done = state == toi_pkg::TOI_EXEC && wcnt >= op.nw && rcnt >= op.nr; // RULE24

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state <= toi_pkg::TOI_BOOT;
        end else begin
            case (state)
                toi_pkg::TOI_BOOT: state <= toi_pkg::TOI_IDLE;
                toi_pkg::TOI_IDLE: begin
                    if (wr_micro) begin
                        state <= toi_pkg::TOI_EXEC; // RULE23
                    end
                end
                toi_pkg::TOI_EXEC: begin
                    if (wcnt < op.nw) begin
                        state <= toi_pkg::TOI_WAIT_WR; // RULE24
                    end else if (rcnt < op.nr) begin
                        state <= toi_pkg::TOI_WAIT_RD; // RULE3
                    end else begin
                        state <= toi_pkg::TOI_IDLE; // RULE24
                    end
                end
                toi_pkg::TOI_WAIT_WR: begin
                    if (wr_micro) begin
                        state <= toi_pkg::TOI_EXEC;
                    end
                end
                toi_pkg::TOI_WAIT_RD: begin
                    if (rd_micro) begin
                        state <= toi_pkg::TOI_EXEC; // RULE3
                    end
                end
                default: state <= toi_pkg::TOI_IDLE;
            endcase
        end
    end

    // Opcode and operand capture
    always_ff @(posedge core_clk) begin
        if (rst) begin
            opcode <= 16'h0000;
            wcnt <= 4'h0;
            rcnt <= 4'h0;
        end else if (state == toi_pkg::TOI_IDLE && wr_micro) begin
            opcode <= bus.wdata;
            wcnt <= 4'h0;
            rcnt <= 4'h0;
        end else if (state == toi_pkg::TOI_WAIT_WR && wr_micro) begin
            wcnt <= wcnt + 4'h1; // RULE19
        end else if (state == toi_pkg::TOI_WAIT_RD && rd_micro) begin
            rcnt <= rcnt + 4'h1; // RULE14
        end
    end

    always_ff @(posedge core_clk) begin
        if (state == toi_pkg::TOI_WAIT_WR && wr_micro) begin
            opnd[wcnt[2:0]] <= bus.wdata;
        end
    end

    // Answer word for the read operand about to be offered
    always_comb begin
        next_rd_word = 16'h0000;
        case (cmd)
            toi_pkg::TOI_C_RD_MODE: next_rd_word[0] = cfg.user.trig_match; // RULE4
            toi_pkg::TOI_C_RD_FIFO: next_rd_word[2:0] = cfg.fifo_size;
            toi_pkg::TOI_C_RD_PAT: next_rd_word = cfg.user.ch_enable[rcnt[2:0]*16 +: 16];
            toi_pkg::TOI_C_GET_TRIM: next_rd_word[11:0] = cfg.rc_trim[obj[1:0]]; // RULE18
            toi_pkg::TOI_C_RD_ID: next_rd_word = chip_stat[obj[1:0]].id[rcnt[0]*16 +: 16]; // RULE14
            toi_pkg::TOI_C_RD_SETUP: next_rd_word = setup_mem[obj[6:0]]; // RULE17
            toi_pkg::TOI_C_RD_ERR: next_rd_word[10:0] = chip_stat[obj[1:0]].err; // RULE16
            toi_pkg::TOI_C_RD_LOCK: next_rd_word[0] = chip_stat[obj[1:0]].dll_lock; // RULE15
            toi_pkg::TOI_C_NV_RD: next_rd_word = {opnd[0][7:0], nv_mem[opnd[0][7:0]]}; // RULE22
            default: next_rd_word = 16'h0000;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            rd_word <= 16'h0000;
        end else if (state == toi_pkg::TOI_EXEC && wcnt >= op.nw && rcnt < op.nr) begin
            rd_word <= next_rd_word;
        end
    end

    // Read port: data stand in the cycle after the strobe, zero otherwise
    always_ff @(posedge core_clk) begin
        if (rst || !bus.rd) begin
            rdata <= 16'h0000;
        end else begin
            case (bus.addr)
                toi_pkg::TOI_ADDR_MICRO: rdata <= read_ok ? rd_word : 16'h0000;
                toi_pkg::TOI_ADDR_HSHAKE: begin
                    rdata <= 16'h0000;
                    rdata[toi_pkg::TOI_HS_WRITE_OK] <= write_ok;
                    rdata[toi_pkg::TOI_HS_READ_OK] <= read_ok;
                end
                toi_pkg::TOI_ADDR_STATUS: rdata <= {9'h000, auto_load, cfg.test_mode,
                    cfg.fault_tag, cfg.fault_skip, cfg.keep_token, cfg.auto_reject,
                    cfg.user.trig_match};
                default: rdata <= 16'h0000;
            endcase
        end
    end

    // Configuration applied by commands and at reset
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cfg <= '0;
            cfg.user <= toi_pkg::TOI_USER_DEFAULT; // RULE8
        end else if (state == toi_pkg::TOI_BOOT) begin
            cfg.user <= auto_load ? nv_user : toi_pkg::TOI_USER_DEFAULT; // RULE11 RULE12
        end else if (done) begin
            case (cmd)
                toi_pkg::TOI_C_TRG_MATCH: begin
                    cfg.user.trig_match <= 1'b1; // RULE1
                    cfg.auto_reject <= 1'b1;
                    cfg.keep_token <= 1'b1;
                end
                toi_pkg::TOI_C_CONT_STOR: begin
                    cfg.user.trig_match <= 1'b0; // RULE2
                    cfg.auto_reject <= 1'b0;
                    cfg.sub_trg <= 1'b0;
                end
                toi_pkg::TOI_C_SET_TOKEN: cfg.keep_token <= 1'b1; // RULE5
                toi_pkg::TOI_C_CLR_TOKEN: cfg.keep_token <= 1'b0; // RULE6
                toi_pkg::TOI_C_LOAD_DEF: cfg.user <= toi_pkg::TOI_USER_DEFAULT; // RULE7
                toi_pkg::TOI_C_LOAD_USER: cfg.user <= nv_user; // RULE10
                toi_pkg::TOI_C_EN_TAG: cfg.fault_tag <= 1'b1; // RULE21
                toi_pkg::TOI_C_DIS_TAG: cfg.fault_tag <= 1'b0; // RULE21
                toi_pkg::TOI_C_EN_SKIP: cfg.fault_skip <= 1'b1; // RULE21
                toi_pkg::TOI_C_DIS_SKIP: cfg.fault_skip <= 1'b0; // RULE21
                toi_pkg::TOI_C_SET_FIFO: cfg.fifo_size <= opnd[0][2:0]; // RULE20
                toi_pkg::TOI_C_EN_CH: cfg.user.ch_enable[obj[6:0]] <= 1'b1;
                toi_pkg::TOI_C_DIS_CH: cfg.user.ch_enable[obj[6:0]] <= 1'b0;
                toi_pkg::TOI_C_EN_ALL: cfg.user.ch_enable <= '1;
                toi_pkg::TOI_C_DIS_ALL: cfg.user.ch_enable <= '0;
                toi_pkg::TOI_C_WR_PAT: begin
                    for (int i = 0; i < 8; i++) begin
                        cfg.user.ch_enable[i*16 +: 16] <= opnd[i]; // RULE19
                    end
                end
                toi_pkg::TOI_C_SET_TRIM: cfg.rc_trim[obj[1:0]] <= opnd[0][11:0]; // RULE18
                toi_pkg::TOI_C_TEST_ON: begin
                    cfg.test_mode <= 1'b1;
                    cfg.test_word <= {opnd[1][7:0], opnd[0]};
                end
                toi_pkg::TOI_C_TEST_OFF: cfg.test_mode <= 1'b0;
                default: cfg.test_mode <= cfg.test_mode;
            endcase
        end
    end

    // Reprogramming strobes, one cycle each
    always_ff @(posedge core_clk) begin
        if (rst) begin
            setup_reprog <= 1'b0;
            ctrl_reprog <= 1'b0;
            setup_default <= 1'b0;
        end else begin
            setup_reprog <= state == toi_pkg::TOI_BOOT || (done && op.rs); // RULE17
            ctrl_reprog <= state == toi_pkg::TOI_BOOT || (done && op.rc); // RULE19
            setup_default <= done && cmd == toi_pkg::TOI_C_DEF_SETUP; // RULE17
        end
    end

    always_ff @(posedge core_clk) begin
        if (done && cmd == toi_pkg::TOI_C_WR_SETUP) begin
            setup_mem[obj[6:0]] <= opnd[0]; // RULE17
        end
        setup_data <= setup_mem[setup_idx];
    end

    // Non-volatile store: survives rst, cleared only by nv_init
    always_ff @(posedge core_clk) begin
        if (nv_init) begin
            auto_load <= 1'b0;
            nv_user <= toi_pkg::TOI_USER_DEFAULT;
            for (int i = 0; i < 256; i++) begin
                nv_mem[i] <= 8'h00;
            end
        end else if (done) begin
            case (cmd)
                toi_pkg::TOI_C_SAVE_USER: nv_user <= cfg.user; // RULE9
                toi_pkg::TOI_C_AUTO_USER: auto_load <= 1'b1; // RULE11
                toi_pkg::TOI_C_AUTO_DEF: auto_load <= 1'b0; // RULE12
                toi_pkg::TOI_C_NV_WR: nv_mem[opnd[0][7:0]] <= opnd[1][7:0]; // RULE22
                default: auto_load <= auto_load;
            endcase
        end
    end

    sequence seq_bare_opcode;
        state == toi_pkg::TOI_IDLE && wr_micro && toi_pkg::toi_decode(bus.wdata[15:8]).nw == 4'h0
            && toi_pkg::toi_decode(bus.wdata[15:8]).nr == 4'h0;
    endsequence
    sequence seq_finish;
        ##1 state == toi_pkg::TOI_EXEC ##1 state == toi_pkg::TOI_IDLE;
    endsequence

    AST_TRG_MODE: assert property (@(posedge core_clk) disable iff (rst) // RULE1
        done && cmd == toi_pkg::TOI_C_TRG_MATCH |=> cfg.user.trig_match && cfg.auto_reject
            && cfg.keep_token) else $error("trigger matching not fully set");
    AST_CONT_MODE: assert property (@(posedge core_clk) disable iff (rst) // RULE2
        done && cmd == toi_pkg::TOI_C_CONT_STOR |=> !cfg.user.trig_match && !cfg.auto_reject
            && !cfg.sub_trg) else $error("continuous storage not fully set");
    AST_QUERY_WAIT: assert property (@(posedge core_clk) disable iff (rst) // RULE3
        state == toi_pkg::TOI_WAIT_RD && !rd_micro |=> state == toi_pkg::TOI_WAIT_RD)
        else $error("left read wait without a read");
    AST_MODE_LSB: assert property (@(posedge core_clk) disable iff (rst) // RULE4
        read_ok && rd_micro && cmd == toi_pkg::TOI_C_RD_MODE
            |=> rdata == {15'h0000, $past(cfg.user.trig_match)})
        else $error("mode query word wrong");
    AST_TOKEN: assert property (@(posedge core_clk) disable iff (rst) // RULE6
        done && cmd == toi_pkg::TOI_C_CLR_TOKEN |=> !cfg.keep_token)
        else $error("token holding not cleared");
    AST_DEFAULTS: assert property (@(posedge core_clk) disable iff (rst) // RULE7
        done && cmd == toi_pkg::TOI_C_LOAD_DEF |=> cfg.user == toi_pkg::TOI_USER_DEFAULT)
        else $error("defaults not loaded");
    AST_AUTOLOAD: assert property (@(posedge core_clk) disable iff (rst) // RULE11
        done && cmd == toi_pkg::TOI_C_AUTO_USER |=> auto_load ##1 auto_load)
        else $error("auto-load flag not set");
    AST_WO_DROP: assert property (@(posedge core_clk) disable iff (rst) // RULE23
        wr_micro && write_ok |=> !write_ok) else $error("write-ok not dropped");
    AST_BARE_DONE: assert property (@(posedge core_clk) disable iff (rst) // RULE24
        seq_bare_opcode |-> seq_finish) else $error("bare opcode did not finish");
endmodule

// ===== toi_pkg.sv
package toi_pkg;
    // Register map of the plain software port
    localparam logic [3:0] TOI_ADDR_MICRO = 4'h0;
    localparam logic [3:0] TOI_ADDR_HSHAKE = 4'h1;
    localparam logic [3:0] TOI_ADDR_STATUS = 4'h2;
    localparam int TOI_HS_WRITE_OK = 0;
    localparam int TOI_HS_READ_OK = 1;

    // Command byte values
    localparam logic [7:0] TOI_C_TRG_MATCH = 8'h00;
    localparam logic [7:0] TOI_C_CONT_STOR = 8'h01;
    localparam logic [7:0] TOI_C_RD_MODE = 8'h02;
    localparam logic [7:0] TOI_C_SET_TOKEN = 8'h03;
    localparam logic [7:0] TOI_C_CLR_TOKEN = 8'h04;
    localparam logic [7:0] TOI_C_LOAD_DEF = 8'h05;
    localparam logic [7:0] TOI_C_SAVE_USER = 8'h06;
    localparam logic [7:0] TOI_C_LOAD_USER = 8'h07;
    localparam logic [7:0] TOI_C_AUTO_USER = 8'h08;
    localparam logic [7:0] TOI_C_AUTO_DEF = 8'h09;
    localparam logic [7:0] TOI_C_EN_TAG = 8'h35;
    localparam logic [7:0] TOI_C_DIS_TAG = 8'h36;
    localparam logic [7:0] TOI_C_EN_SKIP = 8'h37;
    localparam logic [7:0] TOI_C_DIS_SKIP = 8'h38;
    localparam logic [7:0] TOI_C_SET_FIFO = 8'h3b;
    localparam logic [7:0] TOI_C_RD_FIFO = 8'h3c;
    localparam logic [7:0] TOI_C_EN_CH = 8'h40;
    localparam logic [7:0] TOI_C_DIS_CH = 8'h41;
    localparam logic [7:0] TOI_C_EN_ALL = 8'h42;
    localparam logic [7:0] TOI_C_DIS_ALL = 8'h43;
    localparam logic [7:0] TOI_C_WR_PAT = 8'h44;
    localparam logic [7:0] TOI_C_RD_PAT = 8'h45;
    localparam logic [7:0] TOI_C_SET_TRIM = 8'h54;
    localparam logic [7:0] TOI_C_GET_TRIM = 8'h55;
    localparam logic [7:0] TOI_C_RD_ID = 8'h60;
    localparam logic [7:0] TOI_C_WR_SETUP = 8'h70;
    localparam logic [7:0] TOI_C_RD_SETUP = 8'h71;
    localparam logic [7:0] TOI_C_LD_SETUP = 8'h72;
    localparam logic [7:0] TOI_C_DEF_SETUP = 8'h73;
    localparam logic [7:0] TOI_C_RD_ERR = 8'h74;
    localparam logic [7:0] TOI_C_RD_LOCK = 8'h75;
    localparam logic [7:0] TOI_C_NV_WR = 8'hc0;
    localparam logic [7:0] TOI_C_NV_RD = 8'hc1;
    localparam logic [7:0] TOI_C_TEST_ON = 8'hc5;
    localparam logic [7:0] TOI_C_TEST_OFF = 8'hc6;

    // Default trigger window, in 25 ns units
    localparam logic [11:0] TOI_DEF_WIDTH = 12'h014;
    localparam logic [11:0] TOI_DEF_OFFSET = 12'hfd8;
    localparam logic [11:0] TOI_DEF_REJECT = 12'h004;
    localparam logic [11:0] TOI_DEF_SEARCH = 12'h008;
    localparam int TOI_CHANNELS = 128;
    localparam int TOI_CHIPS = 4;

    typedef enum logic [4:0] {
        TOI_BOOT    = 5'b0_0001,
        TOI_IDLE    = 5'b0_0010,
        TOI_EXEC    = 5'b0_0100,
        TOI_WAIT_WR = 5'b0_1000,
        TOI_WAIT_RD = 5'b1_0000
    } toi_state_type;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [3:0]  addr;
        logic [15:0] wdata;
    } toi_bus_type;

    typedef struct packed {
        logic        dll_lock;
        logic [10:0] err;
        logic [31:0] id;
    } toi_chip_type;

    typedef struct packed {
        logic                    trig_match;
        logic [11:0]             win_width;
        logic [11:0]             win_offset;
        logic [11:0]             rej_margin;
        logic [11:0]             search_margin;
        logic [TOI_CHANNELS-1:0] ch_enable;
    } toi_user_type;

    typedef struct packed {
        toi_user_type         user;
        logic                 auto_reject;
        logic                 sub_trg;
        logic                 keep_token;
        logic [2:0]           fifo_size;
        logic                 fault_skip;
        logic                 fault_tag;
        logic                 test_mode;
        logic [23:0]          test_word;
        logic [3:0][11:0]     rc_trim;
    } toi_cfg_type;

    localparam toi_user_type TOI_USER_DEFAULT = '{1'b0, TOI_DEF_WIDTH, TOI_DEF_OFFSET,
        TOI_DEF_REJECT, TOI_DEF_SEARCH, {TOI_CHANNELS{1'b1}}};

    // Operand counts {writes, reads} and setup/control reprogramming
    typedef struct packed {
        logic [3:0] nw;
        logic [3:0] nr;
        logic       rs;
        logic       rc;
    } toi_op_type;

    function automatic toi_op_type toi_decode(input logic [7:0] c);
        toi_op_type o;
        o = '{4'h0, 4'h0, 1'b0, 1'b0};
        case (c)
            TOI_C_TRG_MATCH, TOI_C_CONT_STOR, TOI_C_SET_TOKEN, TOI_C_CLR_TOKEN,
            TOI_C_LOAD_DEF, TOI_C_LOAD_USER, TOI_C_EN_TAG, TOI_C_DIS_TAG,
            TOI_C_EN_SKIP, TOI_C_DIS_SKIP, TOI_C_LD_SETUP, TOI_C_DEF_SETUP,
            TOI_C_TEST_OFF: o.rs = 1'b1;
            TOI_C_RD_MODE, TOI_C_RD_FIFO, TOI_C_GET_TRIM, TOI_C_RD_SETUP,
            TOI_C_RD_ERR, TOI_C_RD_LOCK: o.nr = 4'h1;
            TOI_C_SET_FIFO, TOI_C_SET_TRIM: o = '{4'h1, 4'h0, 1'b1, 1'b0};
            TOI_C_EN_CH, TOI_C_DIS_CH, TOI_C_EN_ALL, TOI_C_DIS_ALL: o.rc = 1'b1;
            TOI_C_WR_PAT: o = '{4'h8, 4'h0, 1'b0, 1'b1};
            TOI_C_RD_PAT: o.nr = 4'h8;
            TOI_C_RD_ID: o.nr = 4'h2;
            TOI_C_WR_SETUP: o.nw = 4'h1;
            TOI_C_NV_WR: o.nw = 4'h2;
            TOI_C_NV_RD: o = '{4'h1, 4'h1, 1'b0, 1'b0};
            TOI_C_TEST_ON: o = '{4'h2, 4'h0, 1'b1, 1'b0};
            default: o.rs = 1'b0;
        endcase
        return o;
    endfunction
endpackage

// ===== toi_host_model.sv
`timescale 1ns/1ps
module toi_host_model (
    input  wire logic            core_clk,
    input  wire logic            write_ok,
    input  wire logic            read_ok,
    input  wire logic [15:0]     rdata,
    output toi_pkg::toi_bus_type bus
);
    initial bus = '0;
    // Only the MICRO location is handshaked; other registers never stall
    task automatic wait_ok(input logic [3:0] a, input logic w);
        int n;
        n = 0;
        while (a == toi_pkg::TOI_ADDR_MICRO && (w ? write_ok : read_ok) !== 1'b1 && n < 64) begin
            @(posedge core_clk);
            n++;
        end
    endtask
    task automatic put(input logic [3:0] a, input logic [15:0] d);
        @(posedge core_clk);
        wait_ok(a, 1'b1);
        bus <= '{1'b1, 1'b0, a, d};
        @(posedge core_clk);
        bus <= '{1'b0, 1'b0, a, ~d};
    endtask
    task automatic get(input logic [3:0] a, output logic [15:0] q);
        @(posedge core_clk);
        wait_ok(a, 1'b0);
        bus <= '{1'b0, 1'b1, a, 16'h0000};
        @(posedge core_clk);
        bus <= '{1'b0, 1'b0, a, 16'hffff};
        @(posedge core_clk);
        q = rdata;
    endtask
endmodule

// ===== tb_toi_opcode_interp.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin errors++; \
    $display("unexpected at %0t: %h vs %h", $time, (a), (b)); end end
module tb_toi_opcode_interp;
    import toi_pkg::*;
    localparam logic [3:0] M = TOI_ADDR_MICRO;
    logic                 core_clk = 1'b0;
    logic                 rst = 1'b1;
    logic                 nv_init = 1'b1;
    toi_bus_type          bus;
    logic [15:0]          rdata, setup_data, q, w;
    toi_chip_type [3:0]   chip_stat = '0;
    logic [6:0]           setup_idx = 7'h00;
    toi_cfg_type          cfg;
    toi_user_type         u;
    logic                 setup_reprog, setup_default, ctrl_reprog, write_ok, read_ok;
    logic [127:0]         pat;
    int                   errors = 0, checked = 0, cyc = 0, n_sr = 0, n_cr = 0, n_sd = 0, k;
    logic [7:0]           ft [4] = '{TOI_C_EN_SKIP, TOI_C_EN_TAG, TOI_C_DIS_SKIP, TOI_C_DIS_TAG};
    logic [1:0]           fx [4] = '{2'b01, 2'b11, 2'b10, 2'b00};
    always #25 core_clk = ~core_clk;
    toi_opcode_interp dut_u (.core_clk(core_clk), .rst(rst), .nv_init(nv_init), .bus(bus),
        .rdata(rdata), .chip_stat(chip_stat), .setup_idx(setup_idx), .setup_data(setup_data),
        .cfg(cfg), .setup_reprog(setup_reprog), .setup_default(setup_default),
        .ctrl_reprog(ctrl_reprog), .write_ok(write_ok), .read_ok(read_ok));
    toi_host_model host_u (.core_clk(core_clk), .write_ok(write_ok), .read_ok(read_ok),
        .rdata(rdata), .bus(bus));
    task final_report;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        n_sr <= n_sr + int'(setup_reprog);
        n_cr <= n_cr + int'(ctrl_reprog);
        n_sd <= n_sd + int'(setup_default);
        if (cyc == 30000) begin
            errors++;
            final_report();
        end
    end
    task do_reset;
        rst <= 1'b1;
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        nv_init <= 1'b0;
        repeat (3) @(posedge core_clk);
    endtask
    // Command results land on the first edge after the host lets go of the strobe
    task settle;
        repeat (3) @(posedge core_clk);
        #1;
    endtask
    task cmd(input logic [7:0] c, input logic [7:0] o);
        host_u.put(M, {c, o});
    endtask
    task tdone(input string s);
        $display("test %s done", s);
    endtask
    initial begin
        void'($urandom(89047));
        for (int i = 0; i < 4; i++) chip_stat[i] <= 44'({$urandom(), $urandom()});
        do_reset();
        `CHK(cfg.user, TOI_USER_DEFAULT)
        tdone("boot");
        cmd(TOI_C_TRG_MATCH, 8'($urandom()));
        settle();
        `CHK({cfg.user.trig_match, cfg.auto_reject, cfg.keep_token}, 3'b111)
        cmd(TOI_C_RD_MODE, 8'h00);
        host_u.get(TOI_ADDR_HSHAKE, q);
        `CHK(q[1:0], 2'b10)
        host_u.get(M, q);
        `CHK(q, 16'h0001)
        cmd(TOI_C_CONT_STOR, 8'($urandom()));
        settle();
        `CHK({cfg.user.trig_match, cfg.auto_reject, cfg.sub_trg}, 3'b000)
        cmd(TOI_C_RD_MODE, 8'h00);
        host_u.get(M, q);
        `CHK(q, 16'h0000)
        cmd(TOI_C_SET_TOKEN, 8'h00);
        settle();
        `CHK(cfg.keep_token, 1'b1)
        cmd(TOI_C_CLR_TOKEN, 8'h00);
        settle();
        `CHK(cfg.keep_token, 1'b0)
        tdone("mode");
        w = 16'($urandom());
        k = n_sr;
        cmd(TOI_C_SET_FIFO, 8'h00);
        host_u.put(M, w);
        settle();
        `CHK(cfg.fifo_size, w[2:0])
        `CHK(n_sr, k + 1)
        cmd(TOI_C_RD_FIFO, 8'h00);
        host_u.get(M, q);
        `CHK(q, {13'h0000, w[2:0]})
        k = n_cr;
        cmd(TOI_C_WR_PAT, 8'h00);
        for (int i = 0; i < 8; i++) begin
            pat[16*i+:16] = 16'($urandom());
            host_u.put(M, pat[16*i+:16]);
        end
        settle();
        `CHK(cfg.user.ch_enable, pat)
        `CHK(n_cr, k + 1)
        u = TOI_USER_DEFAULT;
        u.ch_enable = pat;
        cmd(TOI_C_SAVE_USER, 8'h00);
        cmd(TOI_C_LOAD_DEF, 8'h00);
        settle();
        `CHK(cfg.user, TOI_USER_DEFAULT)
        cmd(TOI_C_LOAD_USER, 8'h00);
        settle();
        `CHK(cfg.user, u)
        cmd(TOI_C_AUTO_USER, 8'h00);
        host_u.get(TOI_ADDR_STATUS, q);
        `CHK(q[6], 1'b1)
        cmd(TOI_C_LOAD_DEF, 8'h00);
        settle();
        do_reset();
        `CHK(cfg.user, u)
        cmd(TOI_C_AUTO_DEF, 8'h00);
        settle();
        do_reset();
        `CHK(cfg.user, TOI_USER_DEFAULT)
        tdone("config");
        for (int i = 0; i < 4; i++) begin
            cmd(TOI_C_RD_ID, 8'(i));
            host_u.get(M, q);
            `CHK(q, chip_stat[i].id[15:0])
            host_u.get(M, q);
            `CHK(q, chip_stat[i].id[31:16])
            cmd(TOI_C_RD_LOCK, 8'(i));
            host_u.get(M, q);
            `CHK(q, {15'h0000, chip_stat[i].dll_lock})
            cmd(TOI_C_RD_ERR, 8'(i));
            host_u.get(M, q);
            `CHK(q, {5'h00, chip_stat[i].err})
            w = 16'($urandom());
            cmd(TOI_C_SET_TRIM, 8'(i));
            host_u.put(M, w);
            settle();
            `CHK(cfg.rc_trim[i], w[11:0])
            cmd(TOI_C_GET_TRIM, 8'(i));
            host_u.get(M, q);
            `CHK(q, {4'h0, w[11:0]})
        end
        tdone("chips");
        for (int j = 0; j < 4; j++) begin
            k = n_sr;
            cmd(ft[j], 8'h00);
            settle();
            `CHK({cfg.fault_tag, cfg.fault_skip}, fx[j])
            `CHK(n_sr, k + 1)
        end
        w = 16'($urandom());
        cmd(TOI_C_NV_WR, 8'h00);
        host_u.put(M, {8'h00, w[15:8]});
        host_u.put(M, {8'h00, w[7:0]});
        cmd(TOI_C_NV_RD, 8'h00);
        host_u.put(M, {8'h00, w[15:8]});
        host_u.get(M, q);
        `CHK(q, w)
        cmd(TOI_C_WR_SETUP, {1'b0, w[14:8]});
        host_u.put(M, w);
        cmd(TOI_C_RD_SETUP, {1'b0, w[14:8]});
        host_u.get(M, q);
        `CHK(q, w)
        setup_idx <= w[14:8];
        k = n_sr;
        cmd(TOI_C_LD_SETUP, 8'h00);
        settle();
        `CHK(setup_data, w)
        `CHK(n_sr, k + 1)
        host_u.get(4'h9, q);
        `CHK(q, 16'h0000)
        k = n_sr;
        cmd(TOI_C_DEF_SETUP, 8'h00);
        settle();
        `CHK(n_sr, k + 1)
        `CHK(n_sd, 1)
        cmd(TOI_C_DIS_ALL, 8'h00);
        cmd(TOI_C_EN_CH, 8'h25);
        cmd(TOI_C_RD_PAT, 8'h00);
        for (int i = 0; i < 8; i++) begin
            host_u.get(M, q);
            `CHK(q, (i == 2) ? 16'h0020 : 16'h0000)
        end
        host_u.get(M, q);
        `CHK(q, 16'h0000)
        cmd(TOI_C_TEST_ON, 8'h00);
        host_u.put(M, w);
        host_u.put(M, {8'h00, w[15:8]});
        settle();
        `CHK({cfg.test_mode, cfg.test_word}, {1'b1, w[15:8], w})
        tdone("misc");
        final_report();
    end
endmodule
